/* pkg/sp4_pkg.sv */
// sp4_pkg: constants, register map and carrier types for the four-mode
// serial port. assumes a 200 MHz sys_clk and a 32-bit apb master.
package sp4_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] SP4_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] SP4_ADDR_BUFFER = 8'h04;
    localparam logic [7:0] SP4_ADDR_RATE = 8'h08;
    localparam logic [7:0] SP4_ADDR_STATUS = 8'h0c;

    // ==========================================================
    // control register field positions
    localparam int SP4_CTL_RXFLAG = 0;
    localparam int SP4_CTL_TXFLAG = 1;
    localparam int SP4_CTL_RX9 = 2;
    localparam int SP4_CTL_TX9 = 3;
    localparam int SP4_CTL_REN = 4;
    localparam int SP4_CTL_MPF = 5;
    localparam int SP4_CTL_MLO = 6;
    localparam int SP4_CTL_MHI = 7;
    // rate register: bit 8 doubles the rate, bits 7:0 timer 1 reload
    localparam int SP4_RATE_DBL = 8;
    localparam logic [7:0] SP4_RELOAD_RESET = 8'h00;

    // ==========================================================
    // timing
    localparam int SP4_STATES_PER_CYCLE = 6;
    localparam int SP4_CPU_PRESCALE = 2;
    localparam logic [3:0] SP4_VOTE_A = 4'h7;
    localparam logic [3:0] SP4_VOTE_B = 4'h8;
    localparam logic [3:0] SP4_VOTE_C = 4'h9;
    localparam logic [8:0] SP4_RX_SEED_ASYNC = 9'h1ff;
    localparam logic [7:0] SP4_RX_SEED_SYNC = 8'hfe;

    typedef enum logic [1:0] {
        SP4_MODE_SHIFT,
        SP4_MODE_UART8,
        SP4_MODE_UART9_FIXED,
        SP4_MODE_UART9_VAR
    } sp4_mode_t;

    typedef enum logic [1:0] {
        SP4_RX_HUNT,
        SP4_RX_FRAME,
        SP4_RX_HOLD
    } sp4_rx_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sp4_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sp4_apb_rsp_t;

    typedef struct packed {
        logic rxd_out;
        logic rxd_oe;
        logic txd;
    } sp4_pins_t;
endpackage

/* hw/sp4_serial_port.sv */
// sp4_serial_port: four-mode serial port with an apb register slave.
// assumes apb signals and the rxd input are synchronous to sys_clk.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps

module sp4_serial_port
    import sp4_pkg::*;
#(
    parameter int CPU_DIV = SP4_CPU_PRESCALE
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire sp4_apb_req_t apb_req,
    output sp4_apb_rsp_t apb_rsp,
    input wire logic rxd_in,
    output sp4_pins_t pins
);

    // ==========================================================
    // state
    typedef struct packed {
        sp4_apb_rsp_t rsp;
        sp4_pins_t pins;
        logic [7:0] control;
        logic rate_double_select;
        logic [7:0] reload;
        logic [7:0] serial_buffer;
        logic [3:0] prescale;
        logic [2:0] phase;
        logic [7:0] timer1;
        logic t1_half;
        logic [4:0] m2_div;
        logic [3:0] tx_div;
        logic [3:0] rx_div;
        logic tx_req;
        logic tx_send;
        logic tx_data;
        logic tx_first;
        logic [8:0] tx_shift;
        logic rx_prev;
        sp4_rx_state_t rx_state;
        logic [8:0] rx_shift;
        logic [2:0] votes;
        logic rx_sync_active;
        logic rx_sync_arm;
    } sp4_state_t;

    sp4_state_t cur;
    sp4_state_t next_cur;
    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    // bits arrive lsb first but enter the shifter from the right
    function automatic logic [7:0] rev8(input logic [7:0] v);
        rev8 = {<<{v}};
    endfunction

    // ==========================================================
    // combinational next state
    always_comb
    begin
        logic state_end;
        logic cycle_end;
        logic tick16;
        logic tx_roll;
        logic rx_roll;
        logic wr;
        logic rd_access;
        logic voted;
        sp4_mode_t mode;
        logic [8:0] shifted;
        shifted = {1'b0, cur.tx_shift[8:1]};
        next_cur = cur;
        next_cur.rsp.pready = 1'b0;
        next_cur.rsp.pslverr = 1'b0;
        mode = sp4_mode_t'({cur.control[SP4_CTL_MHI],
                            cur.control[SP4_CTL_MLO]});
        state_end = (cur.prescale == 4'(CPU_DIV - 1));
        cycle_end = state_end && (cur.phase == 3'(SP4_STATES_PER_CYCLE - 1));
        next_cur.prescale = state_end ? 4'h0 : cur.prescale + 4'h1;
        if (state_end)
        begin
            next_cur.phase = (cur.phase == 3'(SP4_STATES_PER_CYCLE - 1))
                ? 3'h0 : cur.phase + 3'h1;
        end
        // baud tick source: 16x rate
        tick16 = 1'b0;
        if (mode == SP4_MODE_UART9_FIXED)
        begin
            // rate tick every state, then halved unless doubling
            if (state_end)
            begin
                next_cur.m2_div = cur.m2_div + 5'h1;
                tick16 = cur.rate_double_select ? 1'b1 : cur.m2_div[0];
            end
        end
        else if (cycle_end)
        begin
            // timer 1 counts machine cycles, auto-reload
            if (cur.timer1 == 8'hff)
            begin
                next_cur.timer1 = cur.reload;
                next_cur.t1_half = ~cur.t1_half;
                tick16 = cur.rate_double_select | cur.t1_half;
            end
            else
            begin
                next_cur.timer1 = cur.timer1 + 8'h01;
            end
        end
        tx_roll = tick16 && (cur.tx_div == 4'hf);
        if (tick16)
        begin
            next_cur.tx_div = cur.tx_div + 4'h1;
        end

        // apb slave: answer in the access cycle's next edge
        wr = 1'b0;
        rd_access = apb_req.psel && apb_req.penable && !cur.rsp.pready;
        if (rd_access)
        begin
            next_cur.rsp.pready = 1'b1;
            next_cur.rsp.prdata = 32'h0000_0000;
            if (apb_req.pwrite)
            begin
                case (apb_req.paddr)
                    SP4_ADDR_CONTROL:
                    begin
                        // software may only clear the flags; set wins
                        next_cur.control = apb_req.pwdata[7:0];
                        next_cur.control[SP4_CTL_RXFLAG] =
                            cur.control[SP4_CTL_RXFLAG] &
                            apb_req.pwdata[SP4_CTL_RXFLAG];
                        next_cur.control[SP4_CTL_TXFLAG] =
                            cur.control[SP4_CTL_TXFLAG] &
                            apb_req.pwdata[SP4_CTL_TXFLAG];
                    end
                    SP4_ADDR_BUFFER: wr = 1'b1;
                    SP4_ADDR_RATE:
                    begin
                        next_cur.reload = apb_req.pwdata[7:0];
                        next_cur.rate_double_select =
                            apb_req.pwdata[SP4_RATE_DBL];
                    end
                    SP4_ADDR_STATUS: ;
                    default: next_cur.rsp.pslverr = 1'b1;
                endcase
            end
            else
            begin
                case (apb_req.paddr)
                    SP4_ADDR_CONTROL:
                        next_cur.rsp.prdata = {24'h00_0000, cur.control};
                    SP4_ADDR_BUFFER:
                        next_cur.rsp.prdata = {24'h00_0000,
                                               cur.serial_buffer};
                    SP4_ADDR_RATE:
                        next_cur.rsp.prdata = {23'h00_0000,
                            cur.rate_double_select, cur.reload};
                    SP4_ADDR_STATUS:
                        next_cur.rsp.prdata = {26'h000_0000, cur.rx_state,
                            cur.rx_sync_active, cur.tx_data, cur.tx_send,
                            cur.tx_req};
                    default: next_cur.rsp.pslverr = 1'b1;
                endcase
            end
        end

        // ======================================================
        // transmitter
        if (wr)
        begin
            // marker one in mode 0/1, programmed ninth bit in 2/3
            next_cur.tx_shift = {(mode[1] ? cur.control[SP4_CTL_TX9]
                                          : 1'b1),
                                 apb_req.pwdata[7:0]};
            next_cur.tx_req = 1'b1;
            next_cur.tx_data = 1'b0;
            next_cur.tx_send = 1'b0;
        end
        else if (mode == SP4_MODE_SHIFT)
        begin
            // send rises at the first machine cycle end after the write
            if (cur.tx_req && cycle_end)
            begin
                next_cur.tx_req = 1'b0;
                next_cur.tx_send = 1'b1;
            end
            else if (cur.tx_send && cycle_end)
            begin
                if (cur.tx_shift[8:1] == 8'h01)
                begin
                    next_cur.tx_send = 1'b0;
                    next_cur.control[SP4_CTL_TXFLAG] = 1'b1;
                end
                next_cur.tx_shift = {1'b0, cur.tx_shift[8:1]};
            end
        end
        else if (tx_roll)
        begin
            if (cur.tx_req)
            begin
                next_cur.tx_req = 1'b0;
                next_cur.tx_send = 1'b1;
            end
            else if (cur.tx_send && !cur.tx_data)
            begin
                next_cur.tx_data = 1'b1;
                next_cur.tx_first = 1'b1;
            end
            else if (cur.tx_send)
            begin
                // mode 1: marker ends it; modes 2/3: stop one then zeros
                shifted[8] = mode[1] && cur.tx_first;
                next_cur.tx_first = 1'b0;
                if (!cur.tx_first && cur.tx_shift[8:1] == 8'h01)
                begin
                    next_cur.tx_send = 1'b0;
                    next_cur.tx_data = 1'b0;
                    next_cur.control[SP4_CTL_TXFLAG] = 1'b1;
                end
                next_cur.tx_shift = shifted;
            end
        end

        // ======================================================
        // receiver
        rx_roll = 1'b0;
        voted = majority(cur.votes);
        if (mode == SP4_MODE_SHIFT)
        begin
            next_cur.rx_state = SP4_RX_HUNT;
            if (!cur.rx_sync_active && !cur.rx_sync_arm &&
                cur.control[SP4_CTL_REN] &&
                !cur.control[SP4_CTL_RXFLAG])
            begin
                next_cur.rx_sync_arm = 1'b1;
            end
            else if (cur.rx_sync_arm && cycle_end)
            begin
                next_cur.rx_sync_arm = 1'b0;
                next_cur.rx_sync_active = 1'b1;
                next_cur.rx_shift = {1'b1, SP4_RX_SEED_SYNC};
            end
            else if (cur.rx_sync_active)
            begin
                if (state_end && cur.phase == 3'h4)
                begin
                    next_cur.votes[0] = rxd_in;
                end
                if (cycle_end)
                begin
                    next_cur.rx_shift = {cur.rx_shift[7:0], cur.votes[0]};
                    if (!cur.rx_shift[7])
                    begin
                        // filter bit plays no part here
                        next_cur.serial_buffer = rev8({cur.rx_shift[6:0],
                            cur.votes[0]});
                        next_cur.rx_sync_active = 1'b0;
                        next_cur.control[SP4_CTL_RXFLAG] = 1'b1;
                    end
                end
            end
        end
        else
        begin
            next_cur.rx_sync_active = 1'b0;
            next_cur.rx_sync_arm = 1'b0;
            next_cur.rx_prev = rxd_in;
            if (tick16)
            begin
                next_cur.rx_div = cur.rx_div + 4'h1;
                rx_roll = (cur.rx_div == 4'hf);
                if (cur.rx_div == SP4_VOTE_A)
                    next_cur.votes[0] = rxd_in;
                if (cur.rx_div == SP4_VOTE_B)
                    next_cur.votes[1] = rxd_in;
                if (cur.rx_div == SP4_VOTE_C)
                    next_cur.votes[2] = rxd_in;
            end
            case (cur.rx_state)
                SP4_RX_HUNT:
                begin
                    if (cur.control[SP4_CTL_REN] && cur.rx_prev && !rxd_in)
                    begin
                        next_cur.rx_div = 4'h0;
                        next_cur.rx_shift = SP4_RX_SEED_ASYNC;
                        next_cur.rx_state = SP4_RX_FRAME;
                    end
                end
                SP4_RX_FRAME:
                begin
                    if (rx_roll)
                    begin
                        next_cur.rx_shift = {cur.rx_shift[7:0], voted};
                        if (cur.rx_shift == SP4_RX_SEED_ASYNC && voted)
                        begin
                            next_cur.rx_state = SP4_RX_HUNT;
                        end
                        else if (mode == SP4_MODE_UART8 &&
                                 !cur.rx_shift[8])
                        begin
                            // start bit at the top: stop bit is `voted`
                            if (!cur.control[SP4_CTL_RXFLAG] &&
                                (!cur.control[SP4_CTL_MPF] || voted))
                            begin
                                next_cur.serial_buffer =
                                    rev8(cur.rx_shift[7:0]);
                                next_cur.control[SP4_CTL_RX9] = voted;
                                next_cur.control[SP4_CTL_RXFLAG] = 1'b1;
                            end
                            next_cur.rx_state = SP4_RX_HUNT;
                        end
                        else if (mode[1] && !cur.rx_shift[8])
                        begin
                            // ninth bit just voted in
                            if (!cur.control[SP4_CTL_RXFLAG] &&
                                (!cur.control[SP4_CTL_MPF] || voted))
                            begin
                                next_cur.serial_buffer =
                                    rev8(cur.rx_shift[7:0]);
                                next_cur.control[SP4_CTL_RX9] = voted;
                                next_cur.control[SP4_CTL_RXFLAG] = 1'b1;
                            end
                            next_cur.rx_state = SP4_RX_HOLD;
                        end
                    end
                end
                SP4_RX_HOLD:
                begin
                    // stop bit time passes before hunting again
                    if (rx_roll)
                        next_cur.rx_state = SP4_RX_HUNT;
                end
                default: next_cur.rx_state = SP4_RX_HUNT;
            endcase
        end

        // ======================================================
        // pins
        if (mode == SP4_MODE_SHIFT)
        begin
            next_cur.pins.rxd_oe = cur.tx_send;
            next_cur.pins.rxd_out = cur.tx_shift[0];
            if (cur.tx_send || cur.rx_sync_active)
                next_cur.pins.txd = !(next_cur.phase >= 3'h2 &&
                                      next_cur.phase <= 3'h4);
            else
                next_cur.pins.txd = 1'b1;
        end
        else
        begin
            next_cur.pins.rxd_oe = 1'b0;
            next_cur.pins.rxd_out = 1'b1;
            next_cur.pins.txd = !next_cur.tx_send ? 1'b1 :
                (next_cur.tx_data ? next_cur.tx_shift[0] : 1'b0);
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.pins.txd <= 1'b1;
            cur.pins.rxd_out <= 1'b1;
            cur.rx_prev <= 1'b1;
            cur.rx_state <= SP4_RX_HUNT;
            cur.reload <= SP4_RELOAD_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end
    assign apb_rsp = cur.rsp;
    assign pins = cur.pins;
endmodule

/* test/sp4_serial_port_assertions.sv */
// sp4_serial_port_assertions: port-level checks for the serial port.
// assumes one sys_clk domain and a master that keeps the apb rules.
`timescale 1ns/100ps
module sp4_serial_port_assertions
    import sp4_pkg::*;
#(
    parameter int CPU_DIV = SP4_CPU_PRESCALE
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire sp4_apb_req_t apb_req,
    input wire sp4_apb_rsp_t apb_rsp,
    input wire logic rxd_in,
    input wire sp4_pins_t pins
);
    // ==========================================================
    // helper: mode as last written, length of each low clock phase
    logic [1:0] mode;
    logic [7:0] lo_cnt;
    logic acc;
    logic mapped;
    assign acc = apb_req.psel && apb_req.penable;
    assign mapped = apb_req.paddr inside {SP4_ADDR_CONTROL,
        SP4_ADDR_BUFFER, SP4_ADDR_RATE, SP4_ADDR_STATUS};
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mode <= 2'b00;
            lo_cnt <= 8'h00;
        end
        else
        begin
            if (acc && apb_rsp.pready && apb_req.pwrite &&
                apb_req.paddr == SP4_ADDR_CONTROL)
                mode <= apb_req.pwdata[7:6];
            lo_cnt <= pins.txd ? 8'h00 : lo_cnt + 8'h01;
        end
    end

    // ==========================================================
    // properties
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_answer_next_cycle: assert property (acc && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("no answer after one wait state");
    a_ready_needs_access: assert property (apb_rsp.pready
        |-> acc && $past(acc)) else $error("pready outside an access");
    a_error_unmapped: assert property (acc && !apb_rsp.pready && !mapped
        |=> apb_rsp.pslverr) else $error("unmapped access not refused");
    a_no_error_mapped: assert property (acc && !apb_rsp.pready && mapped
        |=> !apb_rsp.pslverr) else $error("mapped access refused");
    a_upper_read_zero: assert property (apb_rsp.pready && !apb_req.pwrite
        |-> apb_rsp.prdata[31:9] == 23'h00_0000)
        else $error("upper read bits not zero");
    a_reset_idle: assert property ($fell(rst)
        |-> pins.txd && !pins.rxd_oe && !apb_rsp.pready)
        else $error("outputs not idle after reset");
    a_data_pin_mode0: assert property (pins.rxd_oe |-> mode == 2'b00)
        else $error("data pin driven outside mode 0");
    a_clock_low_width: assert property ($rose(pins.txd) && mode == 2'b00
        |-> lo_cnt == 8'(3 * CPU_DIV)) else $error("shift clock low width");
endmodule

bind sp4_serial_port sp4_serial_port_assertions #(.CPU_DIV(CPU_DIV)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rxd_in(rxd_in), .pins(pins));

/* test/sp4_uart_peer.sv */
// sp4_uart_peer: far-side node, an async uart or a mode 0 shift register.
// assumes the bench calls its tasks and sets m0_on for mode 0 work.
`timescale 1ns/100ps
module sp4_uart_peer
    import sp4_pkg::*;
(
    input wire logic sys_clk,
    input wire logic txd,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    output logic line
);
    logic m0_on = 1'b0;
    logic [7:0] m0_tx = 8'h00;
    logic [7:0] m0_cap = 8'h00;
    int m0_idx = 0;
    initial line = 1'b1;

    // data changes while the clock is low, so it is settled at sampling;
    // past the eighth bit the line toggles so stale data cannot pass
    always @(negedge txd)
    begin
        if (m0_on && rxd_oe)
            m0_cap <= {rxd_out, m0_cap[7:1]};
        else if (m0_on)
        begin
            line <= (m0_idx < 8) ? m0_tx[m0_idx[2:0]] : !line;
            m0_idx <= m0_idx + 1;
        end
    end

    task automatic send(input logic [10:0] bits, input int n, input int bt);
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            line <= bits[i];
            repeat (bt - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        line <= 1'b1;
    endtask

    task automatic get(input int n, input int bt, output logic [10:0] v);
        int k;
        k = 0;
        v = '1;
        while (txd !== 1'b0 && k < 5000)
        begin
            @(posedge sys_clk);
            k++;
        end
        repeat (bt / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++)
        begin
            v[i] = txd;
            repeat (bt) @(posedge sys_clk);
        end
    endtask
endmodule

/* test/serial_port_four_mode_test.sv */
// serial_port_four_mode_test: self-checking bench for sp4_serial_port.
// assumes the partner model on the pins and the bound checker.
`timescale 1ns/100ps
module serial_port_four_mode_test
    import sp4_pkg::*;
;
    localparam int CPUD = 1;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    sp4_apb_req_t apb_req = '0;
    sp4_apb_rsp_t apb_rsp;
    logic rxd_in;
    sp4_pins_t pins;
    logic [31:0] rd;
    logic er;
    logic [10:0] fr;
    int num_errors = 0;
    int n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    sp4_serial_port #(.CPU_DIV(CPUD)) dut (.sys_clk(sys_clk), .rst(rst),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .rxd_in(rxd_in), .pins(pins));
    sp4_uart_peer peer (.sys_clk(sys_clk), .txd(pins.txd),
        .rxd_out(pins.rxd_out), .rxd_oe(pins.rxd_oe), .line(rxd_in));

    // ==========================================================
    // expectations
    // reload 0xff gives one timer overflow per machine cycle
    function automatic int bit_clks(input logic [1:0] m, input logic dbl);
        if (m == 2'b10)
            return (dbl ? 16 : 32) * CPUD;
        return 16 * (dbl ? 1 : 2) * SP4_STATES_PER_CYCLE * CPUD;
    endfunction

    function automatic logic [10:0] tx_frame(input logic [1:0] m,
        input logic [7:0] v, input logic n9);
        return {1'b1, (m == 2'b01) ? 1'b1 : n9, v, 1'b0};
    endfunction

    // ==========================================================
    // tasks
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, apb_rsp.pready});
    endtask

    task automatic wait_flag(input logic [31:0] mask);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, SP4_ADDR_CONTROL, 32'h0);
            k++;
        end
        while ((rd & mask) == 0 && k < 2000);
    endtask

    task automatic xfer(input logic [1:0] m, input logic dbl,
        input logic filt, input logic [7:0] v, input logic n9);
        int bt;
        int nb;
        logic ld;
        logic [31:0] old;
        bt = bit_clks(m, dbl);
        nb = (m == 2'b01) ? 10 : 11;
        ld = !filt || n9;
        apb(1'b1, SP4_ADDR_RATE, {23'h0, dbl, 8'hff});
        apb(1'b1, SP4_ADDR_CONTROL, {24'h0, m, filt, 1'b1, n9, 3'b000});
        fork
            apb(1'b1, SP4_ADDR_BUFFER, {24'h0, v});
            peer.get(nb, bt, fr);
        join
        chk("tx frame", {21'h0, tx_frame(m, v, n9)}, {21'h0, fr});
        wait_flag(32'h0000_0002);
        chk("tx flag", 32'h2, rd & 32'h0000_0002);
        apb(1'b0, SP4_ADDR_BUFFER, 32'h0);
        old = rd;
        peer.send(11'h000, 1, 3);
        repeat (bt) @(posedge sys_clk);
        peer.send({1'b1, n9, v, 1'b0}, nb, bt);
        repeat (2 * bt) @(posedge sys_clk);
        apb(1'b0, SP4_ADDR_BUFFER, 32'h0);
        chk("rx data", ld ? {24'h0, v} : old, rd);
        apb(1'b0, SP4_ADDR_CONTROL, 32'h0);
        chk("rx flags", {29'h0, n9, 1'b1, ld}, rd & {29'h0, ld, 2'b11});
        if (ld)
        begin
            peer.send({1'b1, n9, ~v, 1'b0}, nb, bt);
            repeat (2 * bt) @(posedge sys_clk);
            apb(1'b0, SP4_ADDR_BUFFER, 32'h0);
            chk("held data", {24'h0, v}, rd);
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] d;
        void'($urandom(13));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, SP4_ADDR_CONTROL, 32'h0);
        chk("ctl reset", 32'h0, rd);
        apb(1'b0, SP4_ADDR_RATE, 32'h0);
        chk("rate reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        for (int i = 0; i < 4; i++)
            xfer(2'b10, 1'b1, i[1], (i < 2) ? {8{i[0]}} : 8'($urandom),
                i[0]);
        xfer(2'b10, 1'b0, 1'b0, 8'($urandom), 1'b1);
        xfer(2'b01, 1'b1, 1'b0, 8'($urandom), 1'b0);
        xfer(2'b01, 1'b0, 1'b1, 8'($urandom), 1'b0);
        xfer(2'b11, 1'b1, 1'b1, 8'($urandom), 1'b1);
        // mode 0: the partner acts as a shift register
        peer.m0_on = 1'b1;
        apb(1'b1, SP4_ADDR_CONTROL, 32'h0);
        d = 8'($urandom);
        apb(1'b1, SP4_ADDR_BUFFER, {24'h0, d});
        wait_flag(32'h0000_0002);
        chk("m0 tx", {24'h0, d}, {24'h0, peer.m0_cap});
        d = 8'($urandom);
        peer.m0_tx = d;
        peer.m0_idx = 0;
        apb(1'b1, SP4_ADDR_CONTROL, 32'h0000_0030);
        wait_flag(32'h0000_0001);
        apb(1'b0, SP4_ADDR_BUFFER, 32'h0);
        chk("m0 rx", {24'h0, d}, rd);
        wrap_up();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        wrap_up();
    end
endmodule
